/* hw/tt_edge_sync.sv */
// two-flop synchroniser with falling edge pulse per pin
`timescale 1ns/1ps
`include "tt_defs.svh"

module tt_edge_sync #(
  parameter int N = `TT_PIN_NUM
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // pins and edge pulses
  input  wire logic [N-1:0] pins,
  output logic      [N-1:0] fall
);
  import tt_pkg::*;

  typedef struct packed {
    logic [N-1:0] meta;
    logic [N-1:0] sync;
    logic [N-1:0] prev;
    logic [N-1:0] fall;
  } tt_sync_t;

  tt_sync_t s;
  tt_sync_t next_s;

  // edge taken from second and third stage only
  always_comb
  begin
    next_s      = s;
    next_s.meta = pins;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
    next_s.fall = s.prev & ~s.sync;
  end

  // state register, idle high pins
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      s <= '{meta: '1, sync: '1, prev: '1, fall: '0};
    else
      s <= next_s;
  end

  assign fall = s.fall;

endmodule : tt_edge_sync

/* hw/tt_prescaler.sv */
// machine cycle enable, one pulse every DIV core clocks
`timescale 1ns/1ps
`include "tt_defs.svh"

module tt_prescaler #(
  parameter int DIV = `TT_MC_DIV
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // machine cycle pulse
  output logic      tick
);
  import tt_pkg::*;

  localparam int W = $clog2(DIV);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } tt_presc_t;

  tt_presc_t s;
  tt_presc_t next_s;

  // wrap counter and pulse
  always_comb
  begin
    next_s      = s;
    next_s.tick = (s.cnt == LAST);
    next_s.cnt  = (s.cnt == LAST) ? '0 : W'(s.cnt + 1'b1);
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;

endmodule : tt_prescaler

/* hw/tt_timer.sv */
// sixteen-bit timer with auto-reload, capture and baud-rate output
`timescale 1ns/1ps
`include "tt_defs.svh"

// Function
// - overflow sets overflow flag unless a serial clock select is set; software clears
// - trigger edge causing capture or reload with enable set sets external flag
// - rx clock select routes our overflows to receiver, else timer1 overflow, in serial modes 1 and 3 only
// - tx clock select routes our overflows to transmitter, else timer1 overflow, in serial modes 1 and 3 only
// - trigger edges act only with external enable and run control set, also in baud mode
// - counter runs only with run control set; clear means off
// - counter select counts count pin edges, else machine cycles
// - capture select picks capture; ignored and reload forced in baud mode
// - mode decode: off, baud, auto-reload or capture
// - auto-reload mode reloads full counter and sets flag on rollover
// - auto-reload mode trigger edge also reloads and sets external flag
// - capture mode counts freely and flags every overflow
// - capture mode trigger edge copies counter into capture pair, sets flag
// - baud mode external flag still raises its interrupt request
module tt_timer (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  // special function register port
  input  wire tt_pkg::tt_sfr_req_t sfr_req,
  output logic [7:0]               sfr_rdata,
  // external pins
  input  wire logic                count_pin,
  input  wire logic                trigger_pin,
  // serial port side
  input  wire logic [1:0]          serial_mode,
  input  wire logic                timer1_ovf,
  output logic                     tx_baud_tick,
  output logic                     rx_baud_tick,
  // interrupt request flags
  output logic                     overflow_irq,
  output logic                     external_irq
);
  import tt_pkg::*;

  // decoded operating mode
  function automatic tt_mode_t mode_of(input tt_ctrl_t c);
    tt_mode_t m;
    if (!c.run)
      m = TT_OFF;
    else if (c.rx_sel || c.tx_sel)
      m = TT_BAUD;
    else if (c.caps)
      m = TT_CAPTURE;
    else
      m = TT_RELOAD;
    return m;
  endfunction : mode_of

  // serial modes that take a variable baud clock
  function automatic logic var_rate(input logic [1:0] sm);
    return (sm == `TT_SER_MODE1) || (sm == `TT_SER_MODE3);
  endfunction : var_rate

  tt_state_t  s;
  tt_state_t  next_s;
  tt_mode_t   mode;
  logic       mc_tick;
  logic [`TT_PIN_NUM-1:0] pin_fall;
  logic       cnt_edge;
  logic       trig;
  logic       inc;
  logic       ovf_evt;
  logic       serial_var;
  logic       wr_ctrl;
  logic       wr_cnt;
  logic       wr_cap;
  tt_ctrl_t   wctrl;

  // pin synchroniser and falling edges
  tt_edge_sync #(
    .N (`TT_PIN_NUM)
  ) u_edges (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pins    ({trigger_pin, count_pin}),
    .fall    (pin_fall)
  );

  // machine cycle enable
  tt_prescaler #(
    .DIV (`TT_MC_DIV)
  ) u_presc (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tick    (mc_tick)
  );

  // event decode
  always_comb
  begin
    mode       = mode_of(s.ctrl);
    cnt_edge   = pin_fall[`TT_PIN_COUNT];
    inc        = s.ctrl.run
               && (s.ctrl.csel ? cnt_edge : mc_tick);
    ovf_evt    = inc && (s.count == `TT_COUNT_MAX);
    trig       = pin_fall[`TT_PIN_TRIG] && s.ctrl.exen
               && (mode != TT_OFF);
    serial_var = var_rate(serial_mode);
    wr_ctrl    = sfr_req.wr && (sfr_req.addr == `TT_ADDR_CTRL);
    wr_cnt     = sfr_req.wr && ((sfr_req.addr == `TT_ADDR_CNT_LO)
               || (sfr_req.addr == `TT_ADDR_CNT_HI));
    wr_cap     = sfr_req.wr && ((sfr_req.addr == `TT_ADDR_CAP_LO)
               || (sfr_req.addr == `TT_ADDR_CAP_HI));
    wctrl      = tt_ctrl_t'(sfr_req.wdata);
  end

  // next state: hardware first, then software writes, with hardware flag sets after the control write
  always_comb
  begin
    next_s         = s;
    next_s.tx_tick = 1'b0;
    next_s.rx_tick = 1'b0;

    // counting and reload or capture
    if (inc)
      next_s.count = 16'(s.count + `TT_COUNT_STEP);
    case (mode)
      TT_RELOAD:
      begin
        if (ovf_evt || trig)
          next_s.count = s.reload;
      end
      TT_CAPTURE:
      begin
        if (trig)
          next_s.reload = s.count;
      end
      TT_BAUD:
      begin
        if (ovf_evt)
          next_s.count = s.reload;
      end
      default:
      begin
        next_s.count = s.count;
      end
    endcase

    // baud clock routing to the serial port
    if (serial_var)
    begin
      next_s.tx_tick = s.ctrl.tx_sel ? (ovf_evt && mode == TT_BAUD)
                                     : timer1_ovf;
      next_s.rx_tick = s.ctrl.rx_sel ? (ovf_evt && mode == TT_BAUD)
                                     : timer1_ovf;
    end

    // software writes; hardware flag sets win over clears
    if (wr_ctrl)
      next_s.ctrl = wctrl;
    if (ovf_evt && (mode == TT_RELOAD || mode == TT_CAPTURE))
      next_s.ctrl.ovf = 1'b1;
    if (trig)
      next_s.ctrl.ext = 1'b1;
    if (sfr_req.wr)
    begin
      case (sfr_req.addr)
        `TT_ADDR_CAP_LO: next_s.reload[7:0]  = sfr_req.wdata;
        `TT_ADDR_CAP_HI: next_s.reload[15:8] = sfr_req.wdata;
        `TT_ADDR_CNT_LO: next_s.count[7:0]   = sfr_req.wdata;
        `TT_ADDR_CNT_HI: next_s.count[15:8]  = sfr_req.wdata;
        default:         next_s.count        = next_s.count;
      endcase
    end

    // registered read data, unmapped reads as zero
    if (sfr_req.rd)
    begin
      case (sfr_req.addr)
        `TT_ADDR_CTRL:   next_s.rdata = s.ctrl;
        `TT_ADDR_CAP_LO: next_s.rdata = s.reload[7:0];
        `TT_ADDR_CAP_HI: next_s.rdata = s.reload[15:8];
        `TT_ADDR_CNT_LO: next_s.rdata = s.count[7:0];
        `TT_ADDR_CNT_HI: next_s.rdata = s.count[15:8];
        default:         next_s.rdata = `TT_RDATA_RESET;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      s.ctrl    <= tt_ctrl_t'(`TT_CTRL_RESET);
      s.reload  <= `TT_DATA_RESET;
      s.count   <= `TT_DATA_RESET;
      s.rdata   <= `TT_RDATA_RESET;
      s.tx_tick <= 1'b0;
      s.rx_tick <= 1'b0;
    end
    else
      s <= next_s;
  end

  // outputs straight from the state register
  assign sfr_rdata    = s.rdata;
  assign tx_baud_tick = s.tx_tick;
  assign rx_baud_tick = s.rx_tick;
  assign overflow_irq = s.ctrl.ovf;
  assign external_irq = s.ctrl.ext;

  // checks on the timer behaviour
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  // overflow in reload or capture mode raises the flag
  property p_ovf_set;
    ovf_evt && (mode == TT_RELOAD || mode == TT_CAPTURE)
      |=> overflow_irq;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow flag not set on overflow");

  // no overflow flag raised in baud mode
  property p_ovf_quiet;
    (mode == TT_BAUD) && !s.ctrl.ovf && !wr_ctrl
      |=> !overflow_irq;
  endproperty
  a_ovf_quiet: assert property (p_ovf_quiet)
    else $error("overflow flag set in baud mode");

  // enabled trigger edge raises the external flag
  property p_ext_set;
    pin_fall[`TT_PIN_TRIG] && s.ctrl.exen && s.ctrl.run
      |=> external_irq;
  endproperty
  a_ext_set: assert property (p_ext_set)
    else $error("external flag not set on trigger");

  // without enable, trigger edges leave the flag alone
  property p_ext_ignored;
    !s.ctrl.exen && !s.ctrl.ext && !wr_ctrl
      |=> !external_irq;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored)
    else $error("external flag set while disabled");

  // rollover in reload mode loads the reload pair
  property p_reload;
    (mode == TT_RELOAD) && ovf_evt && !wr_cnt
      |=> s.count == $past(s.reload);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded on rollover");

  // trigger in capture mode copies the counter
  property p_capture;
    (mode == TT_CAPTURE) && trig && !wr_cap
      |=> s.reload == $past(s.count);
  endproperty
  a_capture: assert property (p_capture)
    else $error("capture pair missed the counter");

  // stopped counter holds its value
  property p_stopped;
    !s.ctrl.run && !wr_cnt |=> $stable(s.count);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  // in capture mode with counter select, no pin edge means no count
  property p_counter_src;
    (mode == TT_CAPTURE) && s.ctrl.csel && !cnt_edge && !wr_cnt && !trig
      |=> $stable(s.count);
  endproperty
  a_counter_src: assert property (p_counter_src)
    else $error("counter moved without a pin edge");

  // our overflow reaches the transmitter in baud mode
  property p_tx_route;
    s.ctrl.tx_sel && s.ctrl.run && ovf_evt && serial_var
      |=> tx_baud_tick;
  endproperty
  a_tx_route: assert property (p_tx_route)
    else $error("transmit tick missing");

  // receiver falls back on timer1 overflow
  property p_rx_route;
    !s.ctrl.rx_sel && timer1_ovf && serial_var |=> rx_baud_tick;
  endproperty
  a_rx_route: assert property (p_rx_route)
    else $error("receive tick not from timer1");

  // a falling count pin edge reaches the counter within four cycles
  property p_pin_edge;
    s.ctrl.run && s.ctrl.csel && $fell(count_pin) && !wr_cnt && !wr_ctrl
      |-> ##[1:4] cnt_edge;
  endproperty
  a_pin_edge: assert property (p_pin_edge)
    else $error("count pin edge lost");

  // capture mode rolls over to zero instead of reloading
  property p_cap_wrap;
    (mode == TT_CAPTURE) && ovf_evt && !wr_cnt
      |=> s.count == 16'($past(s.count) + `TT_COUNT_STEP);
  endproperty
  a_cap_wrap: assert property (p_cap_wrap)
    else $error("capture mode counter did not wrap");

  // trigger in reload mode reloads and flags
  property p_trig_reload;
    (mode == TT_RELOAD) && trig && !wr_cnt
      |=> (s.count == $past(s.reload)) && external_irq;
  endproperty
  a_trig_reload: assert property (p_trig_reload)
    else $error("trigger reload missed");

  // baud mode always reloads on rollover
  property p_baud_reload;
    (mode == TT_BAUD) && ovf_evt && !wr_cnt
      |=> s.count == $past(s.reload);
  endproperty
  a_baud_reload: assert property (p_baud_reload)
    else $error("baud mode rollover not reloaded");

  // trigger never captures while clocking the serial port
  property p_baud_no_capture;
    (mode == TT_BAUD) && trig && !wr_cap
      |=> $stable(s.reload);
  endproperty
  a_baud_no_capture: assert property (p_baud_no_capture)
    else $error("capture pair moved in baud mode");

  // trigger still raises the external flag in baud mode
  property p_baud_ext;
    (mode == TT_BAUD) && trig
      |=> external_irq;
  endproperty
  a_baud_ext: assert property (p_baud_ext)
    else $error("external flag lost in baud mode");

  // our overflow reaches the receiver in baud mode
  property p_rx_own;
    s.ctrl.rx_sel && s.ctrl.run && ovf_evt && serial_var
      |=> rx_baud_tick;
  endproperty
  a_rx_own: assert property (p_rx_own)
    else $error("receive tick missing");

  // fixed rate serial modes get no ticks at all
  property p_fixed_rate;
    !serial_var
      |=> !tx_baud_tick && !rx_baud_tick;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate)
    else $error("tick in fixed rate serial mode");

endmodule : tt_timer

/* shared/tt_defs.svh */
// constants for the sixteen-bit timer with capture and reload
`ifndef TT_DEFS_SVH
`define TT_DEFS_SVH

// register addresses on the special function register port
`define TT_ADDR_CTRL    8'hc8
`define TT_ADDR_CAP_LO  8'hca
`define TT_ADDR_CAP_HI  8'hcb
`define TT_ADDR_CNT_LO  8'hcc
`define TT_ADDR_CNT_HI  8'hcd

// reset values
`define TT_CTRL_RESET   8'h00
`define TT_DATA_RESET   16'h0000
`define TT_RDATA_RESET  8'h00

// counter limits
`define TT_COUNT_MAX    16'hffff
`define TT_COUNT_STEP   16'h0001

// core clocks per machine cycle
`define TT_MC_DIV       12

// serial port modes that take a variable baud rate
`define TT_SER_MODE1    2'h1
`define TT_SER_MODE3    2'h3

// pin slots of the edge synchroniser
`define TT_PIN_COUNT    0
`define TT_PIN_TRIG     1
`define TT_PIN_NUM      2

`endif

/* shared/tt_pkg.sv */
// types for the sixteen-bit timer with capture and reload
package tt_pkg;

  // control register, most significant field first
  typedef struct packed {
    logic ovf;      // overflow_flag
    logic ext;      // external_trigger_flag
    logic rx_sel;   // rx clock select
    logic tx_sel;   // tx_clock_select
    logic exen;     // external_trigger_enable
    logic run;      // run_control
    logic csel;     // counter_select
    logic caps;     // capture_select
  } tt_ctrl_t;

  // operating modes, gray along off, reload, capture, baud
  typedef enum logic [1:0] {
    TT_OFF     = 2'h0,
    TT_RELOAD  = 2'h1,
    TT_CAPTURE = 2'h3,
    TT_BAUD    = 2'h2
  } tt_mode_t;

  // one register port request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } tt_sfr_req_t;

  // whole state of the timer
  typedef struct packed {
    tt_ctrl_t    ctrl;
    logic [15:0] reload;
    logic [15:0] count;
    logic [7:0]  rdata;
    logic        tx_tick;
    logic        rx_tick;
  } tt_state_t;

endpackage : tt_pkg

/* testbench/test_sixteen_bit_timer_capture_reload.sv */
// self-checking bench for the sixteen-bit timer
`timescale 1ns/1ps
`include "tt_defs.svh"

`define TT_CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_sixteen_bit_timer_capture_reload;
  import tt_pkg::*;
  logic        clk_sys;
  logic        nrst;
  tt_sfr_req_t sfr_req;
  logic [7:0]  sfr_rdata;
  logic        count_pin;
  logic        trigger_pin;
  logic [1:0]  serial_mode;
  logic        timer1_ovf;
  logic        tx_baud_tick;
  logic        rx_baud_tick;
  logic        overflow_irq;
  logic        external_irq;
  int          miscompares = 0;
  int          num_checks = 0;
  int          tx_n = 0;
  int          rx_n = 0;

  tt_timer DUT (.clk_sys(clk_sys), .nrst(nrst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .count_pin(count_pin), .trigger_pin(trigger_pin), .serial_mode(serial_mode),
    .timer1_ovf(timer1_ovf), .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick),
    .overflow_irq(overflow_irq), .external_irq(external_irq));

  tt_far_side u_far (.clk_sys(clk_sys), .count_pin(count_pin), .trigger_pin(trigger_pin),
    .serial_mode(serial_mode), .timer1_ovf(timer1_ovf));

  // 200 MHz core clock
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // count baud ticks seen by the serial port
  always @(posedge clk_sys)
  begin
    tx_n <= tx_n + int'(tx_baud_tick === 1'b1);
    rx_n <= rx_n + int'(rx_baud_tick === 1'b1);
  end

  // register port write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_req.addr  = a;
    sfr_req.wdata = d;
    sfr_req.wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_req.wr = 1'b0;
  endtask : wr

  // register port read and compare
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    #1;
    sfr_req.addr = a;
    sfr_req.rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    sfr_req.rd = 1'b0;
    `TT_CHECK(sfr_rdata, e)
  endtask : rd

  // let cycles pass
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  // reset values and unmapped read
  task automatic t_reset();
    rd(`TT_ADDR_CTRL, 8'h00);
    rd(8'hc9, 8'h00);
    rd(`TT_ADDR_CNT_LO, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // auto-reload on rollover, flag clear, stop freezes count
  task automatic t_reload();
    wr(`TT_ADDR_CAP_LO, 8'h34);
    wr(`TT_ADDR_CAP_HI, 8'h12);
    wr(`TT_ADDR_CNT_LO, 8'hfe);
    wr(`TT_ADDR_CNT_HI, 8'hff);
    wr(`TT_ADDR_CTRL, 8'h04);
    for (int i = 0; i < 40 && overflow_irq !== 1'b1; i++) @(posedge clk_sys);
    #1;
    `TT_CHECK(overflow_irq, 1'b1)
    rd(`TT_ADDR_CNT_HI, 8'h12);
    rd(`TT_ADDR_CNT_LO, 8'h34);
    wr(`TT_ADDR_CTRL, 8'h00);
    idle(2);
    `TT_CHECK(overflow_irq, 1'b0)
    idle(30);
    rd(`TT_ADDR_CNT_HI, 8'h12);
    $display("test reload done");
  endtask : t_reload

  // trigger reload, trigger ignored without enable or run
  task automatic t_trig();
    wr(`TT_ADDR_CNT_LO, 8'h55);
    wr(`TT_ADDR_CTRL, 8'h0e);
    u_far.pulse_low(1'b1, 1);
    `TT_CHECK(external_irq, 1'b1)
    rd(`TT_ADDR_CNT_LO, 8'h34);
    wr(`TT_ADDR_CNT_LO, 8'h55);
    wr(`TT_ADDR_CTRL, 8'h06);
    idle(2);
    `TT_CHECK(external_irq, 1'b0)
    u_far.pulse_low(1'b1, 1);
    rd(`TT_ADDR_CNT_LO, 8'h55);
    wr(`TT_ADDR_CTRL, 8'h0a);
    u_far.pulse_low(1'b1, 1);
    `TT_CHECK(external_irq, 1'b0)
    rd(`TT_ADDR_CNT_LO, 8'h55);
    $display("test trigger done");
  endtask : t_trig

  // capture on trigger, then count pin edges
  task automatic t_capture();
    wr(`TT_ADDR_CNT_LO, 8'hcd);
    wr(`TT_ADDR_CNT_HI, 8'hab);
    wr(`TT_ADDR_CTRL, 8'h0f);
    u_far.pulse_low(1'b1, 1);
    `TT_CHECK(external_irq, 1'b1)
    rd(`TT_ADDR_CAP_LO, 8'hcd);
    rd(`TT_ADDR_CAP_HI, 8'hab);
    u_far.pulse_low(1'b0, 3);
    rd(`TT_ADDR_CNT_LO, 8'hd0);
    wr(`TT_ADDR_CNT_HI, 8'hff);
    wr(`TT_ADDR_CNT_LO, 8'hfe);
    u_far.pulse_low(1'b0, 2);
    `TT_CHECK(overflow_irq, 1'b1)
    rd(`TT_ADDR_CNT_HI, 8'h00);
    rd(`TT_ADDR_CAP_HI, 8'hab);
    wr(`TT_ADDR_CTRL, 8'h00);
    $display("test capture done");
  endtask : t_capture

  // baud mode: ticks routed, no overflow flag, forced reload
  task automatic t_baud();
    int tx0;
    int rx0;
    wr(`TT_ADDR_CAP_LO, 8'h34);
    wr(`TT_ADDR_CAP_HI, 8'h12);
    wr(`TT_ADDR_CNT_LO, 8'hfe);
    wr(`TT_ADDR_CNT_HI, 8'hff);
    tx0 = tx_n;
    rx0 = rx_n;
    wr(`TT_ADDR_CTRL, 8'h35);
    idle(40);
    `TT_CHECK(tx_n - tx0, 1)
    `TT_CHECK(rx_n - rx0, 1)
    `TT_CHECK(overflow_irq, 1'b0)
    rd(`TT_ADDR_CNT_HI, 8'h12);
    wr(`TT_ADDR_CTRL, 8'h2d);
    u_far.t1_pulse();
    idle(3);
    `TT_CHECK(tx_n - tx0, 2)
    `TT_CHECK(rx_n - rx0, 1)
    wr(`TT_ADDR_CTRL, 8'h1d);
    u_far.t1_pulse();
    idle(3);
    `TT_CHECK(rx_n - rx0, 2)
    `TT_CHECK(tx_n - tx0, 2)
    u_far.pulse_low(1'b1, 1);
    `TT_CHECK(external_irq, 1'b1)
    u_far.set_mode(2'h2);
    u_far.t1_pulse();
    idle(3);
    `TT_CHECK(tx_n - tx0, 2)
    `TT_CHECK(rx_n - rx0, 2)
    $display("test baud done");
  endtask : t_baud

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // main sequence
  initial
  begin
    nrst    = 1'b0;
    sfr_req = '0;
    repeat (10) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_reset();
    t_reload();
    t_trig();
    t_capture();
    t_baud();
    test_done();
  end

  // watchdog well beyond the few hundred cycles the tests take
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    test_done();
  end
endmodule : test_sixteen_bit_timer_capture_reload

/* testbench/tt_far_side.sv */
// far side model: count and trigger pins, serial mode and timer1 overflow
`timescale 1ns/1ps

module tt_far_side (
  // clock
  input  wire logic  clk_sys,
  // pins toward the timer
  output logic       count_pin,
  output logic       trigger_pin,
  // serial port side
  output logic [1:0] serial_mode,
  output logic       timer1_ovf
);
  // pins rest high on their pull-ups
  initial
  begin
    count_pin   = 1'b1;
    trigger_pin = 1'b1;
    serial_mode = 2'h1;
    timer1_ovf  = 1'b0;
  end

  // four clocks low, four high: wide enough for the synchroniser
  task automatic pulse_low(input bit trig, input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      #1;
      if (trig)
        trigger_pin = 1'b0;
      else
        count_pin = 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      trigger_pin = 1'b1;
      count_pin   = 1'b1;
      repeat (4) @(posedge clk_sys);
    end
  endtask : pulse_low

  // one-cycle timer1 overflow pulse
  task automatic t1_pulse();
    @(posedge clk_sys);
    #1;
    timer1_ovf = 1'b1;
    @(posedge clk_sys);
    #1;
    timer1_ovf = 1'b0;
  endtask : t1_pulse

  // serial port changes its mode
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_sys);
    #1;
    serial_mode = m;
  endtask : set_mode
endmodule : tt_far_side
